// ==== hdl/lir_pkg.sv ====
// Package: register map, field layout and carrier types for the level interrupt routing block
package lir_pkg;

	localparam int unsigned SLOT_COUNT = 12;
	localparam int unsigned REG_WIDTH  = 16;
	localparam int unsigned ADDR_WIDTH = 12;

	// Register indices as printed; byte address is four times the index
	localparam logic [ADDR_WIDTH-1:0] IDX_L0_OUT_X = 12'h016;
	localparam logic [ADDR_WIDTH-1:0] IDX_L1_OUT_X = 12'h017;
	localparam logic [ADDR_WIDTH-1:0] IDX_L0_OUT_Y = 12'h01A;
	localparam logic [ADDR_WIDTH-1:0] IDX_L1_OUT_Y = 12'h01B;
	localparam logic [ADDR_WIDTH-1:0] IDX_FLAG_RD  = 12'h01C;
	localparam int unsigned           IDX_SHIFT    = 2;

	// Field layout
	localparam int unsigned SLOT_LSB = 0;
	localparam int unsigned SLOT_MSB = 11;

	localparam logic [SLOT_COUNT-1:0] MASK_RESET = 12'h000;
	localparam logic [31:0]           READ_ZERO  = 32'h0000_0000;

	// Mask selector, not used by the mask bank
	typedef enum logic [1:0] {
		LIR_SEL_L0_X = 2'h0,
		LIR_SEL_L1_X = 2'h1,
		LIR_SEL_L0_Y = 2'h3,
		LIR_SEL_L1_Y = 2'h2
	} lir_sel_e;

	// Status flags of all slots, both levels
	typedef struct packed {
		logic [SLOT_COUNT-1:0] high_flag;
		logic [SLOT_COUNT-1:0] low_flag;
	} lir_flags_s;

	// The four enable masks
	typedef struct packed {
		logic [SLOT_COUNT-1:0] l0_x;
		logic [SLOT_COUNT-1:0] l1_x;
		logic [SLOT_COUNT-1:0] l0_y;
		logic [SLOT_COUNT-1:0] l1_y;
	} lir_masks_s;

endpackage

// ==== hdl/lir_mask_reg.sv ====
// One twelve-bit enable mask register with write strobe and reset to zero
`timescale 1ns/10ps
module lir_mask_reg #(
	parameter int unsigned WIDTH = 12
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Write side
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	// Stored mask
	output logic      [WIDTH-1:0] mask
);

	// Mask clears on reset so nothing reaches an output until software enables it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= '0;
		end else if (wr_en) begin
			mask <= wr_data;
		end
	end

endmodule

// ==== hdl/lir_level_irq_route.sv ====
// Level threshold interrupt routing: four enable masks over APB, two interrupt outputs
// Register map, one aligned 32-bit word each, bits 31:12 of the mask words and 31:24 of the flag view read as zero:
//   byte 0x58  level0_irq_mask_out_x  level 0 flags of slots A-L onto X
//   byte 0x5C  level1_irq_mask_out_x  level 1 flags of slots A-L onto X
//   byte 0x68  level0_irq_mask_out_y  level 0 flags of slots A-L onto Y
//   byte 0x6C  level1_irq_mask_out_y  level 1 flags of slots A-L onto Y
//   byte 0x70  read-only view of the flags, 11:0 level 0, 23:12 level 1
// The byte address is the word index shifted left by two.
//
// Bus timing:
//   Zero wait states; pready is tied high.
//   A mask write lands at the edge that ends its access cycle.
//   Read data is captured at the edge that ends the setup cycle and
//   holds until the next aligned read setup, so it cannot tear mid-access.
//   A mask write needs byte lanes 0 and 1; otherwise it is dropped quietly,
//   because half a mask would route a slot the software never asked for.
//   Unmapped or misaligned accesses raise pslverr and store nothing.
//   Writes to the flag view are dropped without an error.
//
// Interrupt timing:
//   Both outputs are registered: they follow a flag change, or the edge
//   at which a mask write lands, by one clock. The extra cycle buys pins
//   that never glitch while the masks or flags settle.
//   The flags are levels kept by the status logic; this block never
//   clears them, so an output stays high while any enabled flag is set.
//
// Reset:
//   presetn clears every mask, the read register and both outputs at once,
//   with no clock needed, so nothing is routed until software says so.
//
// Limitation: a misaligned read returns the previous word; the master
// must honour pslverr and drop it.
`timescale 1ns/10ps
module lir_level_irq_route #(
	parameter int unsigned SLOTS = lir_pkg::SLOT_COUNT
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Threshold status flags from the comparators, same clock
	input  wire lir_pkg::lir_flags_s flags,
	// Interrupt outputs
	output logic                    irq_x,
	output logic                    irq_y
);

	// Bus decode
	logic                           access;
	logic                           wr_hit;
	logic                           addr_ok;
	logic                           addr_mapped;
	logic                           rd_setup;
	logic [lir_pkg::ADDR_WIDTH-1:0] index;
	logic [3:0]                     wr_sel;

	// Mask storage and read path
	logic [SLOTS-1:0]               wr_slots;
	lir_pkg::lir_masks_s            masks;
	logic [31:0]                    rd_value;
	logic [31:0]                    prdata_next;

	// Interrupt path
	logic [SLOTS-1:0]               x_low_hits;
	logic [SLOTS-1:0]               x_high_hits;
	logic [SLOTS-1:0]               y_low_hits;
	logic [SLOTS-1:0]               y_high_hits;
	logic                           irq_x_next;
	logic                           irq_y_next;

	// Word index; low two address bits must be zero for an aligned word
	assign index   = paddr[lir_pkg::ADDR_WIDTH+lir_pkg::IDX_SHIFT-1:lir_pkg::IDX_SHIFT];
	assign addr_ok = (paddr[lir_pkg::IDX_SHIFT-1:0] == 2'h0)
		&& (paddr[31:lir_pkg::ADDR_WIDTH+lir_pkg::IDX_SHIFT] == '0);

	// Zero wait states: answer in the first access cycle
	assign access = psel && penable;
	assign pready = 1'b1;

	// Only bits 11:0 are stored; upper lanes are dropped on write
	assign wr_slots = pwdata[lir_pkg::SLOT_MSB:lir_pkg::SLOT_LSB];
	// Byte lanes 0 and 1 must both be written to update a mask; byte 1 holds bits 11:8
	assign wr_hit   = access && pwrite && addr_ok && (pstrb[1:0] == 2'h3);

	// Address decode to the four mask write strobes
	always_comb begin
		wr_sel = 4'h0;
		unique case (index)
			lir_pkg::IDX_L0_OUT_X: wr_sel[0] = wr_hit;
			lir_pkg::IDX_L1_OUT_X: wr_sel[1] = wr_hit;
			lir_pkg::IDX_L0_OUT_Y: wr_sel[2] = wr_hit;
			lir_pkg::IDX_L1_OUT_Y: wr_sel[3] = wr_hit;
			default:               wr_sel = 4'h0;
		endcase
	end

	// Word indices that answer at all; the flag view is read-only but mapped
	always_comb begin
		unique case (index)
			lir_pkg::IDX_L0_OUT_X,
			lir_pkg::IDX_L1_OUT_X,
			lir_pkg::IDX_L0_OUT_Y,
			lir_pkg::IDX_L1_OUT_Y,
			lir_pkg::IDX_FLAG_RD:  addr_mapped = 1'b1;
			default:               addr_mapped = 1'b0;
		endcase
	end

	// Error on unmapped or misaligned access; writes to the flag view are ignored
	assign pslverr = access && !(addr_mapped && addr_ok);

	// The four masks, each in its own register
	// Level 0 mask for output X
	lir_mask_reg #(.WIDTH(SLOTS)) u_l0_x (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_sel[0]),
		.wr_data (wr_slots),
		.mask    (masks.l0_x)
	);

	// Level 1 mask for output X
	lir_mask_reg #(.WIDTH(SLOTS)) u_l1_x (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_sel[1]),
		.wr_data (wr_slots),
		.mask    (masks.l1_x)
	);

	// Level 0 mask for output Y
	lir_mask_reg #(.WIDTH(SLOTS)) u_l0_y (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_sel[2]),
		.wr_data (wr_slots),
		.mask    (masks.l0_y)
	);

	// Level 1 mask for output Y
	lir_mask_reg #(.WIDTH(SLOTS)) u_l1_y (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_sel[3]),
		.wr_data (wr_slots),
		.mask    (masks.l1_y)
	);

	// Read mux; reserved bits 31:12 of the mask words and 31:24 of the flag view return zero
	always_comb begin
		rd_value = lir_pkg::READ_ZERO;
		unique case (index)
			lir_pkg::IDX_L0_OUT_X: rd_value[SLOTS-1:0] = masks.l0_x;
			lir_pkg::IDX_L1_OUT_X: rd_value[SLOTS-1:0] = masks.l1_x;
			lir_pkg::IDX_L0_OUT_Y: rd_value[SLOTS-1:0] = masks.l0_y;
			lir_pkg::IDX_L1_OUT_Y: rd_value[SLOTS-1:0] = masks.l1_y;
			lir_pkg::IDX_FLAG_RD:  rd_value[2*SLOTS-1:0] = {flags.high_flag, flags.low_flag};
			default:               rd_value = lir_pkg::READ_ZERO;
		endcase
	end

	// Read data is registered during the setup cycle so it is stable in the access phase;
	// a misaligned read keeps the old word and relies on pslverr to have it dropped
	assign rd_setup    = psel && !penable && !pwrite && addr_ok;
	assign prdata_next = rd_setup ? rd_value : prdata;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= lir_pkg::READ_ZERO;
		end else begin
			prdata <= prdata_next;
		end
	end

	// Per-slot gating; bit n of every mask is slot n (A = 0 .. L = 11)
	assign x_low_hits  = flags.low_flag & masks.l0_x;
	assign x_high_hits = flags.high_flag & masks.l1_x;
	assign y_low_hits  = flags.low_flag & masks.l0_y;
	assign y_high_hits = flags.high_flag & masks.l1_y;

	// Each output is the OR of every gated flag of both levels
	assign irq_x_next = |x_low_hits || |x_high_hits;
	assign irq_y_next = |y_low_hits || |y_high_hits;

	// Output X registered to keep the pin glitch free, at one cycle of latency
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_x <= 1'b0;
		end else begin
			irq_x <= irq_x_next;
		end
	end

	// Output Y registered the same way, so both pins move on the same edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_y <= 1'b0;
		end else begin
			irq_y <= irq_y_next;
		end
	end

endmodule

// ==== verification/lir_route_sva.sv ====
// Port assertions for the level interrupt routing block
`timescale 1ns/10ps
module lir_route_sva (
	// Bus side
	input logic                pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input logic [31:0]         paddr, pwdata, prdata,
	input logic [3:0]          pstrb,
	// Flags and outputs
	input lir_pkg::lir_flags_s flags,
	input logic                irq_x, irq_y
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase of any transfer
	wire acc = psel && penable;
	sequence s_setup; psel && !penable; endsequence
	sequence s_done; acc && pready; endsequence
	a_zero_wait: assert property (s_setup |=> s_done)
		else $error("no ready after setup");
	a_resv_rd: assert property (acc && !pwrite && paddr != 32'h70 |-> prdata[31:12] == 20'h0)
		else $error("reserved read bits set");
	a_rst_quiet: assert property ($rose(presetn) |-> !irq_x && !irq_y)
		else $error("interrupt out of reset");
	a_idle_quiet: assert property (flags == 24'h0 |=> !irq_x && !irq_y)
		else $error("interrupt with no flag");
	// Outputs only move one edge after a flag change or a register write
	a_irq_stable: assert property ($stable(flags) && !$past(acc && pwrite) |=> $stable({irq_x, irq_y}))
		else $error("interrupt moved without cause");
	a_map_ok: assert property (acc && paddr inside {32'h58, 32'h5C, 32'h68, 32'h6C} |-> !pslverr)
		else $error("mask register refused");
	a_misalign: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access accepted");
	a_x_cause: assert property (irq_x |-> $past(flags) != 24'h0)
		else $error("x raised with no flag");
	a_y_cause: assert property (irq_y |-> $past(flags) != 24'h0)
		else $error("y raised with no flag");
endmodule

bind lir_level_irq_route lir_route_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
	.pslverr, .paddr, .pwdata, .prdata, .pstrb, .flags, .irq_x, .irq_y);

// ==== verification/lir_host_model.sv ====
// Host model: counts interrupt requests it would service
`timescale 1ns/10ps
module lir_host_model (
	// Clock, reset and lines
	input logic        pclk, presetn, irq_x, irq_y,
	// Service count
	output logic [7:0] n_irq
);
	logic req_reg;
	// A new request is a rise of the OR of both lines; a held level is one service only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_reg <= 1'b0;
			n_irq <= 8'h00;
		end else begin
			req_reg <= irq_x | irq_y;
			n_irq <= n_irq + 8'((irq_x | irq_y) & ~req_reg);
		end
	end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the level interrupt routing block
`timescale 1ns/10ps
module tb;
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_x, irq_y;
	logic [31:0]         paddr, pwdata, prdata, v;
	logic [3:0]          pstrb;
	logic [7:0]          n_irq;
	lir_pkg::lir_flags_s flags;
	logic [31:0]         exp_q[$];
	logic [1:0]          irq_q[$];
	logic                err_q[$];
	wire                 xfer_done = psel && penable && pready;
	logic [31:0]         adr[4] = '{32'h58, 32'h5C, 32'h68, 32'h6C};
	int                  failures, n_compared, cyc;

	lir_level_irq_route DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .flags, .irq_x, .irq_y);
	lir_host_model u_host (.pclk, .presetn, .irq_x, .irq_y, .n_irq);

	task automatic chk(input logic [31:0] g, e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("wrong value t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One transfer; an idle edge between transfers avoids double drives
	task automatic apb(input logic [31:0] a, d, input logic w, input logic [3:0] s);
		err_q.push_back(!(a inside {32'h58, 32'h5C, 32'h68, 32'h6C, 32'h70}));
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask
	task automatic rd(input logic [31:0] a, e);
		exp_q.push_back(e);
		apb(a, 32'h0, 1'b0, 4'hF);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Read data checked at its completing edge; cycle ceiling cuts a hang
	always @(posedge pclk) begin
		if (xfer_done && !pwrite && exp_q.size() > 0) chk(prdata, exp_q.pop_front());
		if (xfer_done && err_q.size() > 0) chk(pslverr, err_q.pop_front());
		cyc++;
		if (cyc > 3000) begin
			failures++;
			tally_and_finish();
		end
	end
	// Interrupt levels checked at the falling edge, well clear of the launching edge
	always @(negedge pclk) begin
		if (irq_q.size() > 0) chk({irq_x, irq_y}, irq_q.pop_front());
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb, flags} = '0;
		v = $urandom(32'hF981DD8A);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (adr[i]) rd(adr[i], 32'h0);
		rd(32'h74, 32'h0);
		apb(32'h5A, 32'hFFF, 1'b1, 4'hF);
		rd(32'h58, 32'h0);
		apb(32'h70, 32'hFFF, 1'b1, 4'hF);
		rd(32'h70, 32'h0);
		$display("test reset done");
		// Random data, then a strobe-less write that must not land
		foreach (adr[i]) begin
			v = $urandom;
			apb(adr[i], v, 1'b1, 4'hF);
			rd(adr[i], v & 32'hFFF);
			apb(adr[i], ~v, 1'b1, 4'h0);
			rd(adr[i], v & 32'hFFF);
			apb(adr[i], 32'h0, 1'b1, 4'hF);
		end
		$display("test access done");
		// Each enable bit alone: its own flag routes, the other level does not
		foreach (adr[i]) begin
			for (int s = 0; s < 12; s++) begin
				apb(adr[i], 32'h1 << s, 1'b1, 4'hF);
				flags <= 24'h1 << (s + (i[0] ? 12 : 0));
				repeat (2) @(posedge pclk);
				irq_q.push_back(i < 2 ? 2'h2 : 2'h1);
				@(posedge pclk);
				flags <= 24'h1 << (s + (i[0] ? 0 : 12));
				repeat (2) @(posedge pclk);
				irq_q.push_back(2'h0);
			end
			apb(adr[i], 32'h0, 1'b1, 4'hF);
		end
		chk(n_irq, 32'h30);
		$display("test routing done");
		// Flag view, then a reset in mid-run must clear a live mask and its output
		v = $urandom;
		flags <= 24'(v);
		rd(32'h70, v & 32'hFF_FFFF);
		apb(adr[0], 32'hFFF, 1'b1, 4'hF);
		flags <= 24'hFFF;
		repeat (2) @(posedge pclk);
		irq_q.push_back(2'h2);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		irq_q.push_back(2'h0);
		rd(adr[0], 32'h0);
		$display("test reset in run done");
		tally_and_finish();
	end
endmodule
